// ### hw/scp_pkg.sv
/*
  Shared constants, types and carriers for the serial configuration
  memory output logic.
  Assumes a single 40 MHz system clock samples every pin.
*/
package scp_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 40;
  localparam int POR_NS = 2000; // Internal power-on reset sequence
  localparam int POR_CYC = (POR_NS * CLK_MHZ + 999) / 1000;
  localparam int PULSE_NS = 500; // Least low time of config pulse
  localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // Storage geometry
  // ----------------------------------------------------------------
  localparam int WORD_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int ADDR_W = 16;
  localparam logic [ADDR_W-1:0] TERM_COUNT = 16'hFFFF;

  // ----------------------------------------------------------------
  // Test access port instructions
  // ----------------------------------------------------------------
  localparam int IR_W = 8;
  localparam logic [IR_W-1:0] IR_CAPTURE = 8'h01;
  localparam logic [IR_W-1:0] INS_EXTEST = 8'h00;
  localparam logic [IR_W-1:0] INS_SAMPLE = 8'h01;
  localparam logic [IR_W-1:0] INS_CLAMP = 8'hFA;
  localparam logic [IR_W-1:0] INS_PROG = 8'hE8;
  localparam logic [IR_W-1:0] INS_CONFIG = 8'hEE;
  localparam logic [IR_W-1:0] INS_BYPASS = 8'hFF;

  // ----------------------------------------------------------------
  // Boundary-scan cell positions
  // ----------------------------------------------------------------
  localparam int BSR_LEN = 23;
  localparam int BS_CFGCLK_IN = 0;
  localparam int BS_DATA_OE = 3;
  localparam int BS_DATA_OUT = 4;
  localparam int BS_CHAIN_OE = 11;
  localparam int BS_CHAIN_OUT = 12;
  localparam int BS_CS_IN = 15;
  localparam int BS_OERST_OE = 18;
  localparam int BS_OERST_OUT = 19;
  localparam int BS_OERST_IN = 20;
  localparam int BS_PULSE_OE = 21;
  localparam int BS_PULSE_OUT = 22;

  // ----------------------------------------------------------------
  // Test access port controller states
  // ----------------------------------------------------------------
  typedef enum logic [15:0] {
    TAP_RESET = 16'h0001,
    TAP_IDLE = 16'h0002,
    TAP_SEL_DR = 16'h0004,
    TAP_CAP_DR = 16'h0008,
    TAP_SHIFT_DR = 16'h0010,
    TAP_EXIT1_DR = 16'h0020,
    TAP_PAUSE_DR = 16'h0040,
    TAP_EXIT2_DR = 16'h0080,
    TAP_UPD_DR = 16'h0100,
    TAP_SEL_IR = 16'h0200,
    TAP_CAP_IR = 16'h0400,
    TAP_SHIFT_IR = 16'h0800,
    TAP_EXIT1_IR = 16'h1000,
    TAP_PAUSE_IR = 16'h2000,
    TAP_EXIT2_IR = 16'h4000,
    TAP_UPD_IR = 16'h8000
  } scp_tap_type;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } scp_jtag_in_type;

  typedef struct packed {
    logic level; // Value put on the pin
    logic oe; // High while the pin is driven
  } scp_drive_type;

endpackage

// ### hw/scp_fifo.sv
/*
  Word FIFO between the storage fetch and the bit serialiser.
  Assumes one clock, synchronous active-low reset, and a flush that
  empties it in one cycle.
*/
module scp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk, // System clock
  input wire logic nrst, // Synchronous reset, active low
  input wire logic flush, // Drop all stored words
  input wire logic in_valid, // Word offered
  output logic in_ready, // Room for a word
  input wire logic [WIDTH-1:0] in_data, // Offered word
  output logic out_valid, // Word available
  input wire logic out_ready, // Consumer takes the word
  output logic [WIDTH-1:0] out_data // Oldest word
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [PW:0] count_r;
  logic push;
  logic pop;

  // ----------------------------------------------------------------
  // Handshakes
  // ----------------------------------------------------------------
  assign in_ready = (count_r != (PW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign push = in_valid & in_ready & ~flush;
  assign pop = out_valid & out_ready & ~flush;
  assign out_data = mem_r[rd_ptr_r];

  // Storage needs no reset; only pointers define content
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // Pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge clk) begin
    if (!nrst || flush) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
    end
  end

  // Fill level
  always_ff @(posedge clk) begin
    if (!nrst || flush) begin
      count_r <= '0;
    end else if (push && !pop) begin
      count_r <= count_r + 1'b1;
    end else if (pop && !push) begin
      count_r <= count_r - 1'b1;
    end
  end

endmodule

// ### hw/scp_output_ctrl.sv
/*
  Output-side control of a serial configuration memory: address
  counter, serial data pin, cascade select, reset line, config pulse
  and the boundary-scan test access port.
  Assumes all pins, including the configuration clock and TCK, are
  sampled synchronously by clk, and that the storage array answers a
  read one cycle after the request.
*/
// Overview of operation
// - Count config clock rises when selected, chip select low, reset released.
// - Reset line low clears counter and floats the data pin.
// - Hold reset line low until power-on reset finishes; polarity fixed.
// - Chip select high: standby, counter cleared, data pin floated.
// - Reconfigure instruction pulses the config pulse line low.
// - Cascade select low only when active and counter passed terminal count.
// - Cascade select returns high when reset line low or select high.
// - Stored data leave serially on the single data pin.
// - Programming mode floats the data pin unless clamped.
// - TAP state follows TMS on each TCK rise; TCK sequences test logic.
// - TDI shifts into the selected instruction or data register.
// - Scan cells for data out, data enable and config clock input.
// - Config pulse stays low at least the least pulse width.
module scp_output_ctrl #(
  parameter int WORD_W = scp_pkg::WORD_W,
  parameter int DEPTH = scp_pkg::FIFO_DEPTH,
  parameter int ADDR_W = scp_pkg::ADDR_W,
  parameter logic [ADDR_W-1:0] TERM = scp_pkg::TERM_COUNT
) (
  input wire logic clk, // System clock, 40 MHz
  input wire logic nrst, // Synchronous reset, active low
  input wire logic cfg_clk, // Configuration clock pin
  input wire logic cfg_clk_sel, // High when the clock pin is the source
  input wire logic cs_n, // Chip select, active low
  input wire logic oe_rst_n_in, // Level seen on the reset line
  output scp_pkg::scp_drive_type oe_rst_n_drv, // Open-drain reset drive
  output scp_pkg::scp_drive_type serial_data_out, // Serial data pin
  output scp_pkg::scp_drive_type chain_select_out, // Cascade select, low
  output scp_pkg::scp_drive_type config_pulse_out, // Open-drain pulse
  input scp_pkg::scp_jtag_in_type jtag_in, // TCK, TMS, TDI
  output scp_pkg::scp_drive_type tdo_out, // Test data out
  output logic programming_mode_active, // Programming instruction held
  output logic mem_rd, // Storage read strobe
  output logic [ADDR_W-1:0] mem_addr, // Storage word address
  input wire logic [WORD_W-1:0] mem_rdata, // Word, cycle after strobe
  output logic underrun // Counted edge found no word ready
);

  localparam int BW = $clog2(WORD_W);
  localparam int PCW = $clog2(scp_pkg::POR_CYC + 1);
  localparam int CCW = $clog2(scp_pkg::PULSE_CYC + 1);
  localparam logic [ADDR_W-1:0] LAST_WORD = ADDR_W'(TERM >> BW);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [PCW-1:0] por_cnt_r;
  logic por_done_r;
  logic cfg_clk_q_r;
  logic tck_q_r;
  logic run;
  logic count_en;
  logic [ADDR_W-1:0] addr_cnt_r;
  logic past_term_r;
  logic [ADDR_W-1:0] fetch_addr_r;
  logic fetch_done_r;
  logic rd_pend_r;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [WORD_W-1:0] fifo_out_data;
  logic [WORD_W-1:0] word_r;
  logic [BW-1:0] bit_left_r;
  logic word_valid_r;
  logic data_r;
  logic data_oe_r;
  logic chain_n_r;
  logic [CCW-1:0] pulse_cnt_r;
  logic tck_rise;
  logic tck_fall;
  scp_pkg::scp_tap_type tap_r;
  scp_pkg::scp_tap_type tap_nxt;
  logic [scp_pkg::IR_W-1:0] ir_sh_r;
  logic [scp_pkg::IR_W-1:0] ir_r;
  logic [scp_pkg::BSR_LEN-1:0] bsr_sh_r;
  logic [scp_pkg::BSR_LEN-1:0] bsr_upd_r;
  logic [scp_pkg::BSR_LEN-1:0] bsr_cap;
  logic bypass_r;
  logic tdo_r;
  logic tdo_oe_r;
  logic sel_bsr;
  logic pin_ctl;
  logic clamp;

  // ----------------------------------------------------------------
  // Pin sampling and active condition
  // ----------------------------------------------------------------

  // Previous levels for edge detection
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cfg_clk_q_r <= 1'b0;
      tck_q_r <= 1'b0;
    end else begin
      cfg_clk_q_r <= cfg_clk;
      tck_q_r <= jtag_in.tck;
    end
  end

  // The line reads low while this device itself still pulls it
  assign run = ~cs_n & oe_rst_n_in;
  assign count_en = cfg_clk & ~cfg_clk_q_r & cfg_clk_sel & run;
  assign tck_rise = jtag_in.tck & ~tck_q_r;
  assign tck_fall = ~jtag_in.tck & tck_q_r;

  // Power-on sequence timer releases the reset line when done
  always_ff @(posedge clk) begin
    if (!nrst) begin
      por_cnt_r <= '0;
      por_done_r <= 1'b0;
    end else if (!por_done_r) begin
      por_cnt_r <= por_cnt_r + 1'b1;
      por_done_r <= (por_cnt_r == PCW'(scp_pkg::POR_CYC - 1));
    end
  end

  // ----------------------------------------------------------------
  // Storage fetch into the word FIFO
  // ----------------------------------------------------------------

  // One read outstanding at most, so a ready FIFO always has room
  always_ff @(posedge clk) begin
    if (!nrst || !run) begin
      fetch_addr_r <= '0;
      fetch_done_r <= 1'b0;
      rd_pend_r <= 1'b0;
    end else begin
      rd_pend_r <= mem_rd;
      if (mem_rd) begin
        fetch_addr_r <= fetch_addr_r + 1'b1;
        fetch_done_r <= (fetch_addr_r == LAST_WORD);
      end
    end
  end

  assign mem_rd = run & ~rd_pend_r & ~fetch_done_r & fifo_in_ready;
  assign mem_addr = fetch_addr_r;

  scp_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .flush(~run),
    .in_valid(rd_pend_r),
    .in_ready(fifo_in_ready),
    .in_data(mem_rdata),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  // ----------------------------------------------------------------
  // Address counter and serialiser
  // ----------------------------------------------------------------

  // Cleared while deselected or held in reset
  always_ff @(posedge clk) begin
    if (!nrst || !run) begin
      addr_cnt_r <= '0;
      past_term_r <= 1'b0;
    end else if (count_en && word_valid_r) begin
      addr_cnt_r <= addr_cnt_r + 1'b1;
      if (addr_cnt_r == TERM) begin
        past_term_r <= 1'b1;
      end
    end
  end

  // A new word loads only once the previous one is fully shifted
  assign fifo_pop = ~word_valid_r & fifo_out_valid;

  // Word shifter: bit 0 is the bit at the current address
  always_ff @(posedge clk) begin
    if (!nrst || !run) begin
      word_r <= '0;
      bit_left_r <= '0;
      word_valid_r <= 1'b0;
    end else if (fifo_pop) begin
      word_r <= fifo_out_data;
      bit_left_r <= BW'(WORD_W - 1);
      word_valid_r <= 1'b1;
    end else if (count_en && word_valid_r) begin
      word_r <= word_r >> 1;
      bit_left_r <= bit_left_r - 1'b1;
      word_valid_r <= (bit_left_r != '0);
    end
  end

  // Missed edges are flagged; the clock outran the storage
  always_ff @(posedge clk) begin
    if (!nrst || !run) begin
      underrun <= 1'b0;
    end else if (count_en && !word_valid_r && !past_term_r) begin
      underrun <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  assign pin_ctl = (ir_r == scp_pkg::INS_EXTEST) | clamp;
  assign clamp = (ir_r == scp_pkg::INS_CLAMP);
  assign programming_mode_active = (ir_r == scp_pkg::INS_PROG);

  // Data pin: scan cells override in test, float when not active
  always_ff @(posedge clk) begin
    if (!nrst) begin
      data_r <= 1'b0;
      data_oe_r <= 1'b0;
    end else if (pin_ctl) begin
      data_r <= bsr_upd_r[scp_pkg::BS_DATA_OUT];
      data_oe_r <= bsr_upd_r[scp_pkg::BS_DATA_OE];
    end else begin
      data_r <= word_r[0];
      data_oe_r <= run & word_valid_r & ~programming_mode_active;
    end
  end

  assign serial_data_out.level = data_r;
  assign serial_data_out.oe = data_oe_r;

  // Cascade select, one cycle behind its cause
  always_ff @(posedge clk) begin
    if (!nrst) begin
      chain_n_r <= 1'b1;
    end else if (pin_ctl) begin
      chain_n_r <= bsr_upd_r[scp_pkg::BS_CHAIN_OUT];
    end else if (!run) begin
      chain_n_r <= 1'b1;
    end else begin
      chain_n_r <= ~past_term_r;
    end
  end

  assign chain_select_out.level = chain_n_r;
  assign chain_select_out.oe = pin_ctl ? bsr_upd_r[scp_pkg::BS_CHAIN_OE]
                                       : 1'b1;

  // Reset line is pulled low only; its polarity is not selectable
  assign oe_rst_n_drv.level = 1'b0;
  assign oe_rst_n_drv.oe = ~por_done_r |
    (pin_ctl & bsr_upd_r[scp_pkg::BS_OERST_OE] &
     ~bsr_upd_r[scp_pkg::BS_OERST_OUT]);

  // Config pulse timer, started when the instruction is loaded
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pulse_cnt_r <= '0;
    end else if (tck_rise && tap_r == scp_pkg::TAP_UPD_IR &&
                 ir_sh_r == scp_pkg::INS_CONFIG) begin
      pulse_cnt_r <= CCW'(scp_pkg::PULSE_CYC);
    end else if (pulse_cnt_r != '0) begin
      pulse_cnt_r <= pulse_cnt_r - 1'b1;
    end
  end

  assign config_pulse_out.level = 1'b0;
  assign config_pulse_out.oe = (pulse_cnt_r != '0) |
    (pin_ctl & bsr_upd_r[scp_pkg::BS_PULSE_OE] &
     ~bsr_upd_r[scp_pkg::BS_PULSE_OUT]);

  // ----------------------------------------------------------------
  // Test access port controller
  // ----------------------------------------------------------------

  // Standard sixteen-state walk on TMS
  always_comb begin
    tap_nxt = tap_r;
    case (tap_r)
      scp_pkg::TAP_RESET: begin
        tap_nxt = jtag_in.tms ? scp_pkg::TAP_RESET : scp_pkg::TAP_IDLE;
      end
      scp_pkg::TAP_IDLE, scp_pkg::TAP_UPD_DR, scp_pkg::TAP_UPD_IR: begin
        tap_nxt = jtag_in.tms ? scp_pkg::TAP_SEL_DR : scp_pkg::TAP_IDLE;
      end
      scp_pkg::TAP_SEL_DR: begin
        tap_nxt = jtag_in.tms ? scp_pkg::TAP_SEL_IR : scp_pkg::TAP_CAP_DR;
      end
      scp_pkg::TAP_CAP_DR, scp_pkg::TAP_SHIFT_DR: begin
        tap_nxt = jtag_in.tms ? scp_pkg::TAP_EXIT1_DR
                              : scp_pkg::TAP_SHIFT_DR;
      end
      scp_pkg::TAP_EXIT1_DR: begin
        tap_nxt = jtag_in.tms ? scp_pkg::TAP_UPD_DR
                              : scp_pkg::TAP_PAUSE_DR;
      end
      scp_pkg::TAP_PAUSE_DR: begin
        tap_nxt = jtag_in.tms ? scp_pkg::TAP_EXIT2_DR
                              : scp_pkg::TAP_PAUSE_DR;
      end
      scp_pkg::TAP_EXIT2_DR: begin
        tap_nxt = jtag_in.tms ? scp_pkg::TAP_UPD_DR
                              : scp_pkg::TAP_SHIFT_DR;
      end
      scp_pkg::TAP_SEL_IR: begin
        tap_nxt = jtag_in.tms ? scp_pkg::TAP_RESET : scp_pkg::TAP_CAP_IR;
      end
      scp_pkg::TAP_CAP_IR, scp_pkg::TAP_SHIFT_IR: begin
        tap_nxt = jtag_in.tms ? scp_pkg::TAP_EXIT1_IR
                              : scp_pkg::TAP_SHIFT_IR;
      end
      scp_pkg::TAP_EXIT1_IR: begin
        tap_nxt = jtag_in.tms ? scp_pkg::TAP_UPD_IR
                              : scp_pkg::TAP_PAUSE_IR;
      end
      scp_pkg::TAP_PAUSE_IR: begin
        tap_nxt = jtag_in.tms ? scp_pkg::TAP_EXIT2_IR
                              : scp_pkg::TAP_PAUSE_IR;
      end
      scp_pkg::TAP_EXIT2_IR: begin
        tap_nxt = jtag_in.tms ? scp_pkg::TAP_UPD_IR
                              : scp_pkg::TAP_SHIFT_IR;
      end
      default: begin
        tap_nxt = scp_pkg::TAP_RESET;
      end
    endcase
  end

  // State moves only on a TCK rise
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tap_r <= scp_pkg::TAP_RESET;
    end else if (tck_rise) begin
      tap_r <= tap_nxt;
    end
  end

  // Instruction register: capture, shift, then update
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ir_sh_r <= scp_pkg::IR_CAPTURE;
      ir_r <= scp_pkg::INS_BYPASS;
    end else if (tck_rise) begin
      case (tap_r)
        scp_pkg::TAP_RESET: begin
          ir_r <= scp_pkg::INS_BYPASS;
        end
        scp_pkg::TAP_CAP_IR: begin
          ir_sh_r <= scp_pkg::IR_CAPTURE;
        end
        scp_pkg::TAP_SHIFT_IR: begin
          ir_sh_r <= {jtag_in.tdi, ir_sh_r[scp_pkg::IR_W-1:1]};
        end
        scp_pkg::TAP_UPD_IR: begin
          ir_r <= ir_sh_r;
        end
        default: begin
          ir_r <= ir_r;
        end
      endcase
    end
  end

  assign sel_bsr = (ir_r == scp_pkg::INS_EXTEST) |
                   (ir_r == scp_pkg::INS_SAMPLE);

  // Captured pin levels for the scan chain
  always_comb begin
    bsr_cap = '0;
    bsr_cap[scp_pkg::BS_CFGCLK_IN] = cfg_clk;
    bsr_cap[scp_pkg::BS_DATA_OE] = serial_data_out.oe;
    bsr_cap[scp_pkg::BS_DATA_OUT] = serial_data_out.level;
    bsr_cap[scp_pkg::BS_CHAIN_OE] = chain_select_out.oe;
    bsr_cap[scp_pkg::BS_CHAIN_OUT] = chain_n_r;
    bsr_cap[scp_pkg::BS_CS_IN] = cs_n;
    bsr_cap[scp_pkg::BS_OERST_OE] = oe_rst_n_drv.oe;
    bsr_cap[scp_pkg::BS_OERST_IN] = oe_rst_n_in;
    bsr_cap[scp_pkg::BS_PULSE_OE] = config_pulse_out.oe;
  end

  // Data registers: boundary chain or single bypass bit
  always_ff @(posedge clk) begin
    if (!nrst) begin
      bsr_sh_r <= '0;
      bsr_upd_r <= '0;
      bypass_r <= 1'b0;
    end else if (tck_rise) begin
      if (tap_r == scp_pkg::TAP_CAP_DR) begin
        bsr_sh_r <= sel_bsr ? bsr_cap : bsr_sh_r;
        bypass_r <= 1'b0;
      end else if (tap_r == scp_pkg::TAP_SHIFT_DR) begin
        if (sel_bsr) begin
          bsr_sh_r <= {jtag_in.tdi, bsr_sh_r[scp_pkg::BSR_LEN-1:1]};
        end
        bypass_r <= jtag_in.tdi;
      end else if (tap_r == scp_pkg::TAP_UPD_DR && sel_bsr) begin
        bsr_upd_r <= bsr_sh_r;
      end
    end
  end

  // Test data out changes on the falling TCK edge
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tdo_r <= 1'b1;
      tdo_oe_r <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe_r <= (tap_r == scp_pkg::TAP_SHIFT_DR) |
                  (tap_r == scp_pkg::TAP_SHIFT_IR);
      if (tap_r == scp_pkg::TAP_SHIFT_IR) begin
        tdo_r <= ir_sh_r[0];
      end else begin
        tdo_r <= sel_bsr ? bsr_sh_r[0] : bypass_r;
      end
    end
  end

  assign tdo_out.level = tdo_r;
  assign tdo_out.oe = tdo_oe_r;

endmodule

// ### testbench/scp_output_ctrl_chk.sv
/*
  Checker for the output control block, bound to its top module.
  Assumes one clock and the synchronous active-low reset nrst.
*/
module scp_output_ctrl_chk (
  input wire logic clk, // Clock
  input wire logic nrst, // Reset
  input wire logic cs_n, // Select
  input wire logic oe_rst_n_in, // Line level
  input scp_pkg::scp_drive_type oe_rst_n_drv, // Line pull
  input scp_pkg::scp_drive_type serial_data_out, // Data pin
  input scp_pkg::scp_drive_type chain_select_out, // Cascade
  input scp_pkg::scp_drive_type config_pulse_out, // Pulse
  input wire logic programming_mode_active // Prog mode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  logic [7:0] pulse_len_r;
  // Pulse length; saturates so a stuck pulse cannot wrap to 20
  always_ff @(posedge clk) begin
    if (!nrst || !config_pulse_out.oe) begin
      pulse_len_r <= 8'h00;
    end else if (pulse_len_r != 8'hFF) begin
      pulse_len_r <= pulse_len_r + 8'h01;
    end
  end
  por_pull_a: assert property (
    $rose(nrst) |-> oe_rst_n_drv.oe [*8]) else $error("no power-on pull");
  open_drain_a: assert property (
    !oe_rst_n_drv.level && !config_pulse_out.level) else $error("od level");
  rst_float_a: assert property (
    !oe_rst_n_in [*3] |-> !serial_data_out.oe) else $error("data driven");
  cs_float_a: assert property (
    cs_n [*3] |-> !serial_data_out.oe) else $error("data driven in standby");
  chain_cs_a: assert property (
    cs_n [*3] |-> chain_select_out.level) else $error("cascade low, cs high");
  chain_rst_a: assert property (
    !oe_rst_n_in [*3] |-> chain_select_out.level) else $error("cascade low");
  chain_fall_a: assert property (
    $fell(chain_select_out.level) |-> $past(cs_n, 2) == 1'b0 &&
    $past(oe_rst_n_in, 2)) else $error("cascade fell while idle");
  prog_float_a: assert property (
    programming_mode_active [*2] |-> !serial_data_out.oe)
    else $error("data driven in programming mode");
  pulse_width_a: assert property (
    $fell(config_pulse_out.oe) |-> pulse_len_r == 8'(scp_pkg::PULSE_CYC))
    else $error("config pulse width wrong");
  cover property ($fell(chain_select_out.level));
  cover property ($rose(programming_mode_active));
  cover property ($fell(config_pulse_out.oe));
endmodule

bind scp_output_ctrl scp_output_ctrl_chk u_chk (.clk, .nrst, .cs_n,
  .oe_rst_n_in, .oe_rst_n_drv, .serial_data_out, .chain_select_out,
  .config_pulse_out, .programming_mode_active);

// ### testbench/scp_far_model.sv
/*
  Far side: configuration controller clocking the data pin, the
  pulled-up reset line and a storage array with one-cycle reads.
  Assumes clk is the block's system clock.
*/
module scp_far_model (
  input wire logic clk, // Clock
  input wire logic cfg_go, // Run config clock
  input wire logic hold_n, // Controller pulls line low at 0
  input scp_pkg::scp_drive_type oe_rst_n_drv, // Device pull
  input scp_pkg::scp_drive_type serial_data_out, // Data pin
  input wire logic mem_rd, // Read strobe
  input wire logic [15:0] mem_addr, // Word address
  output logic cfg_clk, // Config clock
  output logic oe_rst_n_in, // Resolved line
  output logic [7:0] mem_rdata, // Read word
  output logic [15:0] cap // Taken bits, newest on top
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph;
  logic bit_now;
  initial begin
    {ph, cfg_clk, cap, mem_rdata} = '0;
  end
  // Pull-up line: low if either party pulls
  assign oe_rst_n_in = hold_n & ~oe_rst_n_drv.oe;
  // Floating pin reads as the inverse of its last value
  assign bit_now = serial_data_out.oe ? serial_data_out.level : ~cap[15];
  // Clock stands still low between runs; a bit is taken at each rise
  always @(posedge clk) begin
    ph <= cfg_go ? ph + 2'd1 : 2'd0;
    cfg_clk <= cfg_go && (ph == 2'd1 || ph == 2'd2);
    if (cfg_go && ph == 2'd1) begin
      cap <= {bit_now, cap[15:1]};
    end
  end
  // Word answers one edge after the strobe, junk otherwise
  always @(posedge clk) begin
    mem_rdata <= mem_rd ? mem_addr[7:0] ^ 8'h5A : ~mem_rdata;
  end
endmodule

// ### testbench/scp_output_ctrl_tb.sv
/*
  Self-checking bench for the output control block.
  Assumes the far-side model and a 40 MHz clock.
*/
module scp_output_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0, sel = 1'b0, cs_n = 1'b1, go = 1'b0, hold_n = 1'b1;
  logic cfg_clk, line, pma, mem_rd, under, next_cs_n;
  logic [15:0] mem_addr, cap;
  logic [7:0] mem_rdata;
  scp_pkg::scp_jtag_in_type jtag_in = '0;
  scp_pkg::scp_drive_type rst_drv, data, chain, pulse, tdo;
  int miscompares = 0, compares = 0, pulse_run = 0, pulse_last = 0;

  always #12.5 clk = ~clk;

  // Cascade count shortened so two words pass before it
  scp_output_ctrl #(.TERM(16'h000F)) dut (.clk(clk), .nrst(nrst),
    .cfg_clk(cfg_clk), .cfg_clk_sel(sel), .cs_n(cs_n),
    .oe_rst_n_in(line), .oe_rst_n_drv(rst_drv), .serial_data_out(data),
    .chain_select_out(chain), .config_pulse_out(pulse), .jtag_in(jtag_in),
    .tdo_out(tdo), .programming_mode_active(pma), .mem_rd(mem_rd),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata), .underrun(under));
  scp_far_model far (.clk(clk), .cfg_go(go), .hold_n(hold_n),
    .oe_rst_n_drv(rst_drv), .serial_data_out(data), .mem_rd(mem_rd),
    .mem_addr(mem_addr), .cfg_clk(cfg_clk), .oe_rst_n_in(line),
    .mem_rdata(mem_rdata), .cap(cap));
  // Cascade select feeds the next memory's chip select
  assign next_cs_n = chain.level;

  // Length of the last config pulse
  always @(posedge clk) begin
    if (pulse.oe === 1'b1) begin
      pulse_run <= pulse_run + 1;
    end else if (pulse_run != 0) begin
      pulse_last <= pulse_run;
      pulse_run <= 0;
    end
  end

  task automatic give_verdict();
    if (miscompares == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // n config clock rises, one every four cycles
  task automatic run_edges(input int n);
    cyc(1);
    go <= 1'b1;
    cyc(4 * n);
    go <= 1'b0;
  endtask
  task automatic tck_bit(input logic tms, input logic tdi);
    jtag_in <= {1'b0, tms, tdi};
    cyc(3);
    jtag_in.tck <= 1'b1;
    cyc(3);
  endtask
  // Reset the port, walk to the instruction shift, load, back to idle
  task automatic load_ir(input logic [7:0] code);
    logic [9:0] walk;
    walk = 10'b0011011111;
    for (int i = 0; i < 10; i++) begin
      tck_bit(walk[i], 1'b1);
    end
    for (int i = 0; i < 8; i++) begin
      tck_bit(i == 7, code[i]);
    end
    chk(tdo.oe, 1'b1);
    tck_bit(1'b1, 1'b1);
    tck_bit(1'b0, 1'b1);
  endtask

  task automatic test_por();
    cyc(2);
    #1;
    chk(rst_drv.oe, 1'b1);
    chk(data.oe, 1'b0);
    chk(chain.level, 1'b1);
    cyc(90);
    #1;
    chk(line, 1'b1);
  endtask
  // Unselected rises are ignored; first two words leave LSB first
  task automatic test_stream();
    cyc(1);
    cs_n <= 1'b0;
    cyc(10);
    run_edges(4);
    sel <= 1'b1;
    cyc(10);
    run_edges(7);
    #1;
    chk(next_cs_n, 1'b1);
    run_edges(9);
    #1;
    chk(cap, 16'h5B5A);
    chk(next_cs_n, 1'b0);
    chk(under, 1'b0);
  endtask
  // Standby or a held reset line floats data and restarts at word 0
  task automatic test_idle(input logic by_cs);
    cyc(1);
    if (by_cs) cs_n <= 1'b1;
    else hold_n <= 1'b0;
    cyc(3);
    #1;
    chk(data.oe, 1'b0);
    chk(chain.level, 1'b1);
    cyc(1);
    cs_n <= 1'b0;
    hold_n <= 1'b1;
    cyc(10);
    run_edges(8);
    #1;
    chk(cap[15:8], 8'h5A);
  endtask
  task automatic test_programming_mode_active();
    cyc(1);
    load_ir(scp_pkg::INS_PROG);
    cyc(4);
    #1;
    chk(pma, 1'b1);
    chk(data.oe, 1'b0);
    cyc(1);
    load_ir(scp_pkg::INS_BYPASS);
    cyc(4);
    #1;
    chk(pma, 1'b0);
  endtask
  task automatic test_config();
    cyc(1);
    load_ir(scp_pkg::INS_CONFIG);
    cyc(30);
    #1;
    chk(16'(pulse_last), 16'(scp_pkg::PULSE_CYC));
  endtask

  initial begin
    cyc(6);
    nrst <= 1'b1;
    test_por();
    test_stream();
    test_idle(1'b1);
    test_idle(1'b0);
    test_programming_mode_active();
    test_config();
    give_verdict();
  end
  // Whole run needs about 700 cycles, well under the 4000-cycle limit
  initial begin
    cyc(4000);
    miscompares++;
    give_verdict();
  end
endmodule
